// ===== core/css_pkg.sv
// Constants, types and register map of the contact-input speed selector.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package css_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYC_DEF = DEBOUNCE_US * CLK_MHZ;
  localparam int SEL_LATENCY_US = 2000;
  localparam int DB_CNT_W = 17;
  // Widths
  localparam int ADDR_W = 8;
  localparam int SPD_W = 14;
  localparam int MODE_W = 4;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] SPD1_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SPD2_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SPD3_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] MAXSPD_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h14;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ROLE_LSB = 4;
  localparam int CTRL_ALLOC_LSB = 8;
  // Reset values
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
  localparam logic [1:0] ROLE_RST = 2'h0;
  localparam logic [2:0] ALLOC_RST = 3'h0;
  localparam logic [SPD_W-1:0] SPD1_RST = 14'h0064;
  localparam logic [SPD_W-1:0] SPD2_RST = 14'h00c8;
  localparam logic [SPD_W-1:0] SPD3_RST = 14'h012c;
  localparam logic [SPD_W-1:0] MAXSPD_RST = 14'h2710;
  // Control mode codes
  localparam logic [MODE_W-1:0] MODE_FB_STOP = 4'h3;
  localparam logic [MODE_W-1:0] MODE_FB_ANALOG = 4'h4;
  localparam logic [MODE_W-1:0] MODE_FB_PULSE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_FB_TORQUE = 4'h6;
  localparam logic [MODE_W-1:0] MODE_SW_7 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_SW_8 = 4'h8;
  localparam logic [MODE_W-1:0] MODE_SPD_TRQ = 4'h9;
  localparam logic [MODE_W-1:0] MODE_ZCLAMP = 4'ha;
  localparam logic [MODE_W-1:0] MODE_INHIBIT = 4'hb;
  localparam logic [MODE_W-1:0] MODE_PI_C = 4'hc;
  localparam logic [MODE_W-1:0] MODE_PI_D = 4'hd;
  localparam logic [MODE_W-1:0] MODE_PI_0 = 4'h0;
  // Torque input role codes
  localparam logic [1:0] ROLE_UNUSED = 2'h0;
  localparam logic [1:0] ROLE_LIMIT = 2'h1;
  localparam logic [1:0] ROLE_FFWD = 2'h2;

  // Reference source, one-hot
  typedef enum logic [5:0] {
    SRC_NONE = 6'b000001,
    SRC_STOP = 6'b000010,
    SRC_PRESET = 6'b000100,
    SRC_ANALOG_SPD = 6'b001000,
    SRC_PULSE = 6'b010000,
    SRC_ANALOG_TRQ = 6'b100000
  } css_src_t;

  // Pulse gate states, one-hot
  typedef enum logic [1:0] {
    GATE_OPEN = 2'b01,
    GATE_WAIT = 2'b10
  } css_gate_t;

  // Contact inputs in logic sense (1 = on)
  typedef struct packed {
    logic dir;
    logic sel_a;
    logic sel_b;
  } css_contacts_t;

  // Software configuration
  typedef struct packed {
    logic [2:0] alloc;
    logic [1:0] role;
    logic [MODE_W-1:0] mode;
  } css_cfg_t;
endpackage

// ===== core/css_top.sv
// Contact-input speed selector with APB register file.
// Assumes raw active-low contact pins and a pulse pin from outside the
// clock domain, and a positioning-done level from the position loop on pclk.
//
// Function
// - Contact pins are active low, so a high or open pin reads as off and a low pin as on.
// - With contact speed selection active, A=0 B=1 picks speed one, A=1 B=1 speed two, A=1 B=0 speed three.
// - With both selects off, fallback mode 3 stops at zero, 4 follows analog speed, 5 pulses, 6 analog torque.
// - With contact speed selection active, the direction input off means forward and on means reverse.
// - Without contact speed selection, the select inputs drive the forward and reverse torque limits.
// - Without contact speed selection, the direction input drives P control, zero clamp or mode switching.
// - Contact speed selection is active only when all three inputs are allocated.
// - In the position fallback only pulse trains are accepted, never serial commands.
// - Soft start runs only in contact selection with mode 5 and never while following pulses.
// - After a switch from a running preset speed to pulses, pulses are dropped until positioning completes.
// - A select input change is recognised within 2 ms.
// - In mode 9 speed control runs while the first contact is on, the torque input acting per its role.
// - A preset speed above the motor maximum is clamped to the maximum.
`timescale 1ns/100ps
module css_top
  import css_pkg::*;
#(
  parameter int DEBOUNCE_CYC = DEBOUNCE_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dir_select_in,
  input wire logic speed_sel_a_in,
  input wire logic speed_sel_b_in,
  input wire logic pulse_ref_in,
  input wire logic serial_cmd_in,
  input wire logic position_done_in,
  output logic position_done_out,
  output logic [SPD_W-1:0] speed_ref_out,
  output logic reverse_out,
  output css_src_t ref_source_out,
  output logic pulse_accept_out,
  output logic serial_accept_out,
  output logic soft_start_out,
  output logic fwd_torque_limit_out,
  output logic rev_torque_limit_out,
  output logic p_control_out,
  output logic zero_clamp_out,
  output logic mode_switch_out,
  output logic inhibit_out,
  output logic speed_ctrl_out,
  output logic torque_limit_en_out,
  output logic torque_ffwd_en_out
);

  localparam logic [DB_CNT_W-1:0] DB_LAST = DB_CNT_W'(DEBOUNCE_CYC - 1);

  function automatic logic [SPD_W-1:0] clamp_speed(input logic [SPD_W-1:0] spd, input logic [SPD_W-1:0] lim);
    clamp_speed = (spd > lim) ? lim : spd;
  endfunction

  function automatic logic mode_any(input logic [MODE_W-1:0] m, input logic [MODE_W-1:0] c0,
                                    input logic [MODE_W-1:0] c1, input logic [MODE_W-1:0] c2);
    mode_any = (m == c0) || (m == c1) || (m == c2);
  endfunction

  function automatic css_src_t fallback_src(input logic [MODE_W-1:0] m);
    case (m)
      MODE_FB_STOP: fallback_src = SRC_STOP;
      MODE_FB_ANALOG: fallback_src = SRC_ANALOG_SPD;
      MODE_FB_PULSE: fallback_src = SRC_PULSE;
      MODE_FB_TORQUE: fallback_src = SRC_ANALOG_TRQ;
      default: fallback_src = SRC_NONE;
    endcase
  endfunction

  css_cfg_t cfg_reg;
  logic [SPD_W-1:0] spd1_reg;
  logic [SPD_W-1:0] spd2_reg;
  logic [SPD_W-1:0] spd3_reg;
  logic [SPD_W-1:0] maxspd_reg;
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pulse_sync_reg;
  css_contacts_t stable_reg;
  logic [DB_CNT_W-1:0] db_cnt_reg [3];
  css_gate_t gate_reg;
  css_gate_t gate_next;
  css_src_t src_prev_reg;
  logic running_reg;
  logic [31:0] rdata_next;
  logic addr_ok;
  logic apb_done;
  logic [2:0] logic_now;
  logic active;
  css_src_t src_next;
  logic [SPD_W-1:0] speed_next;
  logic pulse_edge;
  logic access;
  logic dir_idle;
  logic spd_trq_on;

  assign apb_done = psel & penable & pready;
  assign access = psel & penable & ~pready;

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= access;
      pslverr <= access & ~addr_ok;
    end
  end

  // Read data held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (clk_en && access && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  always_comb begin
    addr_ok = 1'b1;
    rdata_next = 32'h0;
    case (paddr)
      CTRL_OFS: rdata_next = 32'(cfg_reg.mode) | (32'(cfg_reg.role) << CTRL_ROLE_LSB) |
                             (32'(cfg_reg.alloc) << CTRL_ALLOC_LSB);
      SPD1_OFS: rdata_next = 32'(spd1_reg);
      SPD2_OFS: rdata_next = 32'(spd2_reg);
      SPD3_OFS: rdata_next = 32'(spd3_reg);
      MAXSPD_OFS: rdata_next = 32'(maxspd_reg);
      STATUS_OFS: rdata_next = {21'h0, gate_reg == GATE_WAIT, active, stable_reg, ref_source_out};
      default: addr_ok = 1'b0;
    endcase
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '{alloc: ALLOC_RST, role: ROLE_RST, mode: MODE_RST};
      spd1_reg <= SPD1_RST;
      spd2_reg <= SPD2_RST;
      spd3_reg <= SPD3_RST;
      maxspd_reg <= MAXSPD_RST;
    end else if (clk_en && apb_done && pwrite) begin
      case (paddr)
        CTRL_OFS: begin
          cfg_reg.mode <= pwdata[CTRL_MODE_LSB +: MODE_W];
          cfg_reg.role <= pwdata[CTRL_ROLE_LSB +: 2];
          cfg_reg.alloc <= pwdata[CTRL_ALLOC_LSB +: 3];
        end
        SPD1_OFS: spd1_reg <= pwdata[SPD_W-1:0];
        SPD2_OFS: spd2_reg <= pwdata[SPD_W-1:0];
        SPD3_OFS: spd3_reg <= pwdata[SPD_W-1:0];
        MAXSPD_OFS: maxspd_reg <= pwdata[SPD_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 3'h7;
      pin_s2_reg <= 3'h7;
      pulse_sync_reg <= 3'h0;
    end else if (clk_en) begin
      pin_s1_reg <= {dir_select_in, speed_sel_a_in, speed_sel_b_in};
      pin_s2_reg <= pin_s1_reg;
      pulse_sync_reg <= {pulse_sync_reg[1:0], pulse_ref_in};
    end
  end

  assign logic_now = ~pin_s2_reg;
  assign pulse_edge = pulse_sync_reg[1] & ~pulse_sync_reg[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_reg <= '0;
      for (int i = 0; i < 3; i++) begin
        db_cnt_reg[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 3; i++) begin
        if (logic_now[i] == stable_reg[i]) begin
          db_cnt_reg[i] <= '0;
        end else if (db_cnt_reg[i] == DB_LAST) begin
          stable_reg[i] <= logic_now[i];
          db_cnt_reg[i] <= '0;
        end else begin
          db_cnt_reg[i] <= db_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  assign active = (cfg_reg.mode >= MODE_FB_STOP) && (cfg_reg.mode <= MODE_FB_TORQUE) && (&cfg_reg.alloc);
  assign dir_idle = !active && stable_reg.dir;
  assign spd_trq_on = (cfg_reg.mode == MODE_SPD_TRQ) && stable_reg.dir;

  // Reference source decode
  always_comb begin
    src_next = SRC_NONE;
    speed_next = '0;
    if (active) begin
      case ({stable_reg.sel_a, stable_reg.sel_b})
        2'b01: begin
          src_next = SRC_PRESET;
          speed_next = clamp_speed(spd1_reg, maxspd_reg);
        end
        2'b11: begin
          src_next = SRC_PRESET;
          speed_next = clamp_speed(spd2_reg, maxspd_reg);
        end
        2'b10: begin
          src_next = SRC_PRESET;
          speed_next = clamp_speed(spd3_reg, maxspd_reg);
        end
        default: begin
          src_next = fallback_src(cfg_reg.mode);
        end
      endcase
    end
  end

  always_comb begin
    gate_next = gate_reg;
    case (gate_reg)
      GATE_OPEN: begin
        if (src_next == SRC_PULSE && src_prev_reg == SRC_PRESET && running_reg) begin
          gate_next = GATE_WAIT;
        end
      end
      GATE_WAIT: begin
        if (position_done_in || src_next != SRC_PULSE) begin
          gate_next = GATE_OPEN;
        end
      end
      default: gate_next = GATE_OPEN;
    endcase
  end

  // Pulse gate state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg <= GATE_OPEN;
    end else if (clk_en) begin
      gate_reg <= gate_next;
    end
  end

  // Source history for the running test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_reg <= SRC_NONE;
      running_reg <= 1'b0;
    end else if (clk_en) begin
      src_prev_reg <= src_next;
      running_reg <= (src_next == SRC_PRESET) && (speed_next != '0);
    end
  end

  // Positioning-done copy for the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_done_out <= 1'b0;
    end else if (clk_en) begin
      position_done_out <= position_done_in;
    end
  end

  // Reference outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_ref_out <= '0;
      reverse_out <= 1'b0;
      ref_source_out <= SRC_NONE;
      soft_start_out <= 1'b0;
      pulse_accept_out <= 1'b0;
      serial_accept_out <= 1'b0;
    end else if (clk_en) begin
      speed_ref_out <= speed_next;
      ref_source_out <= src_next;
      reverse_out <= active & stable_reg.dir;
      // soft start only on presets in mode 5
      soft_start_out <= active && (cfg_reg.mode == MODE_FB_PULSE) && (src_next == SRC_PRESET);
      pulse_accept_out <= pulse_edge && (src_next == SRC_PULSE) && (gate_next == GATE_OPEN);
      // no serial commands in position fallback
      serial_accept_out <= serial_cmd_in && !active;
    end
  end

  // Reassigned contact functions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_torque_limit_out <= 1'b0;
      rev_torque_limit_out <= 1'b0;
      p_control_out <= 1'b0;
      zero_clamp_out <= 1'b0;
      mode_switch_out <= 1'b0;
      inhibit_out <= 1'b0;
    end else if (clk_en) begin
      fwd_torque_limit_out <= !active && stable_reg.sel_a;
      rev_torque_limit_out <= !active && stable_reg.sel_b;
      p_control_out <= dir_idle &&
                       mode_any(cfg_reg.mode, MODE_PI_0, MODE_PI_C, MODE_PI_D);
      zero_clamp_out <= dir_idle && (cfg_reg.mode == MODE_ZCLAMP);
      mode_switch_out <= dir_idle &&
                         mode_any(cfg_reg.mode, MODE_SW_7, MODE_SW_8, MODE_SPD_TRQ);
      inhibit_out <= dir_idle && (cfg_reg.mode == MODE_INHIBIT);
    end
  end

  // Mode 9 speed control and torque input role
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_ctrl_out <= 1'b0;
      torque_limit_en_out <= 1'b0;
      torque_ffwd_en_out <= 1'b0;
    end else if (clk_en) begin
      // speed control while first contact on
      speed_ctrl_out <= spd_trq_on;
      torque_limit_en_out <= spd_trq_on && (cfg_reg.role == ROLE_LIMIT);
      torque_ffwd_en_out <= spd_trq_on && (cfg_reg.role == ROLE_FFWD);
    end
  end

endmodule

// ===== tb/css_top_properties.sv
// Port checker of the contact-input speed selector.
// Bound into css_top; assumes clk_en held high.
`timescale 1ns/100ps
module css_top_properties
  import css_pkg::*;
#(
  parameter int DEBOUNCE_CYC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic speed_sel_a_in,
  input wire logic position_done_in,
  input wire logic [SPD_W-1:0] speed_ref_out,
  input wire logic reverse_out,
  input wire css_src_t ref_source_out,
  input wire logic pulse_accept_out,
  input wire logic serial_accept_out,
  input wire logic soft_start_out,
  input wire logic fwd_torque_limit_out,
  input wire logic mode_switch_out,
  input wire logic speed_ctrl_out,
  input wire logic torque_limit_en_out,
  input wire logic torque_ffwd_en_out
);
  logic a_q;
  int a_cnt;
  logic idle;
  assign idle = ref_source_out == SRC_NONE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b1;
      a_cnt <= 0;
    end else begin
      a_q <= speed_sel_a_in;
      if (a_q != speed_sel_a_in) begin
        a_cnt <= 0;
      end else if (a_cnt < 1000) begin
        a_cnt <= a_cnt + 1;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_soft; soft_start_out |-> ref_source_out == SRC_PRESET; endproperty
  a_soft: assert property (p_soft) else $error("soft start outside preset");
  property p_gate; $past(ref_source_out) == SRC_PRESET && $past(speed_ref_out) != 0
    && ref_source_out == SRC_PULSE ##0 (!position_done_in) [*6] |-> !pulse_accept_out; endproperty
  a_gate: assert property (p_gate) else $error("pulse accepted while gate closed");
  property p_rev; reverse_out |-> !idle; endproperty
  a_rev: assert property (p_rev) else $error("reverse without contact selection");
  property p_lim; !idle |-> !fwd_torque_limit_out; endproperty
  a_lim: assert property (p_lim) else $error("torque limit during selection");
  property p_msw; !idle |-> !mode_switch_out; endproperty
  a_msw: assert property (p_msw) else $error("mode switch during selection");
  property p_ser; !idle && $past(ref_source_out) != SRC_NONE |-> !serial_accept_out; endproperty
  a_ser: assert property (p_ser) else $error("serial command accepted");
  property p_spd; speed_ctrl_out |-> mode_switch_out; endproperty
  a_spd: assert property (p_spd) else $error("speed control without contact");
  property p_role; torque_limit_en_out || torque_ffwd_en_out |->
    speed_ctrl_out && !(torque_limit_en_out && torque_ffwd_en_out); endproperty
  a_role: assert property (p_role) else $error("torque role conflict");
  property p_seen; idle && !speed_sel_a_in && a_cnt == DEBOUNCE_CYC + 5 |-> fwd_torque_limit_out; endproperty
  a_seen: assert property (p_seen) else $error("select change not seen");
  property p_bounce; $rose(fwd_torque_limit_out) && $past(ref_source_out) == SRC_NONE |-> a_cnt >= DEBOUNCE_CYC;
  endproperty
  a_bounce: assert property (p_bounce) else $error("short glitch accepted");
  c_preset: cover property (ref_source_out == SRC_PRESET && reverse_out);
  c_pulse: cover property (pulse_accept_out);
  c_ffwd: cover property (torque_ffwd_en_out);
endmodule
bind css_top css_top_properties #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_props (.pclk, .presetn, .speed_sel_a_in,
  .position_done_in, .speed_ref_out, .reverse_out, .ref_source_out, .pulse_accept_out, .serial_accept_out,
  .soft_start_out, .fwd_torque_limit_out, .mode_switch_out, .speed_ctrl_out, .torque_limit_en_out,
  .torque_ffwd_en_out);

// ===== tb/css_host.sv
// Host model: drives the contact pins and reference pulses.
// Tasks are entered between edges; pins change just after pclk rises.
`timescale 1ns/100ps
module css_host #(
  parameter int GAP_CYC = 20
) (
  input wire logic pclk,
  input wire logic position_done_out,
  output logic dir_select_in,
  output logic speed_sel_a_in,
  output logic speed_sel_b_in,
  output logic pulse_ref_in
);
  initial begin
    dir_select_in = 1'b1;
    speed_sel_a_in = 1'b1;
    speed_sel_b_in = 1'b1;
    pulse_ref_in = 1'b0;
  end
  task automatic set_pins(input logic d, input logic a, input logic b);
    @(posedge pclk);
    dir_select_in <= !d;
    speed_sel_a_in <= !a;
    speed_sel_b_in <= !b;
  endtask
  task automatic pulses(input int n, input bit obey);
    repeat (GAP_CYC) @(negedge pclk);
    while (obey && position_done_out !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    repeat (n) begin
      pulse_ref_in <= 1'b1;
      repeat (2) @(posedge pclk);
      pulse_ref_in <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule

// ===== tb/tb_contact_input_speed_select.sv
// Self-checking bench of the contact-input speed selector.
// Bench is APB master and position loop; css_host drives the pins.
`timescale 1ns/100ps
module tb_contact_input_speed_select;
  import css_pkg::*;
  localparam int DB = 8;
  localparam int ST = DB + 8;
  logic pclk, presetn, pready, pslverr, err, position_done_out, reverse_out, pulse_accept_out;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clk_en = 1'b1, serial_cmd_in = 1'b0, position_done_in = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic dir_select_in, speed_sel_a_in, speed_sel_b_in, pulse_ref_in, serial_accept_out, soft_start_out;
  logic fwd_torque_limit_out, rev_torque_limit_out, p_control_out, zero_clamp_out, mode_switch_out;
  logic inhibit_out, speed_ctrl_out, torque_limit_en_out, torque_ffwd_en_out;
  logic [SPD_W-1:0] speed_ref_out;
  css_src_t ref_source_out;
  int miscompares = 0, cmp_count = 0, cyc = 0, npulse = 0;
  css_top #(.DEBOUNCE_CYC(DB)) dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .dir_select_in, .speed_sel_a_in, .speed_sel_b_in, .pulse_ref_in,
    .serial_cmd_in, .position_done_in, .position_done_out, .speed_ref_out, .reverse_out, .ref_source_out,
    .pulse_accept_out, .serial_accept_out, .soft_start_out, .fwd_torque_limit_out, .rev_torque_limit_out,
    .p_control_out, .zero_clamp_out, .mode_switch_out, .inhibit_out, .speed_ctrl_out,
    .torque_limit_en_out, .torque_ffwd_en_out);
  css_host host (.pclk, .position_done_out, .dir_select_in, .speed_sel_a_in, .speed_sel_b_in, .pulse_ref_in);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (pulse_accept_out === 1'b1) npulse++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic ser_pulse;
    @(posedge pclk);
    serial_cmd_in <= 1'b1;
    @(posedge pclk);
    serial_cmd_in <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic cfg(input logic [MODE_W-1:0] m, input logic [1:0] r, input logic [2:0] al);
    apb(1'b1, CTRL_OFS, {21'h0, al, 2'h0, r, m});
    wt(2);
  endtask
  task automatic sel(input logic d, input logic a, input logic b);
    host.set_pins(d, a, b);
    wt(ST);
  endtask
  task automatic t_regs;
    apb(1'b0, SPD1_OFS, 32'h0);
    chk("spd1 reset", 32'(SPD1_RST), rd);
    apb(1'b0, MAXSPD_OFS, 32'h0);
    chk("max reset", 32'(MAXSPD_RST), rd);
    apb(1'b1, 8'h40, 32'h5);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped data", 32'h0, rd);
    $display("t_regs done");
  endtask
  task automatic t_decode;
    css_src_t fb[4] = '{SRC_STOP, SRC_ANALOG_SPD, SRC_PULSE, SRC_ANALOG_TRQ};
    cfg(MODE_FB_STOP, ROLE_UNUSED, 3'h7);
    sel(1'b0, 1'b0, 1'b1);
    chk("speed1", 32'(SPD1_RST), 32'(speed_ref_out));
    sel(1'b1, 1'b1, 1'b1);
    chk("speed2", 32'(SPD2_RST), 32'(speed_ref_out));
    chk("reverse", 32'h1, 32'(reverse_out));
    sel(1'b0, 1'b1, 1'b0);
    chk("speed3", 32'(SPD3_RST), 32'(speed_ref_out));
    chk("forward", 32'h0, 32'(reverse_out));
    apb(1'b1, SPD2_OFS, 32'h3fff);
    sel(1'b0, 1'b1, 1'b1);
    chk("clamp", 32'(MAXSPD_RST), 32'(speed_ref_out));
    sel(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cfg(MODE_FB_STOP + 4'(i), ROLE_UNUSED, 3'h7);
      chk("fallback", 32'(fb[i]), 32'(ref_source_out));
    end
    cfg(MODE_FB_STOP, ROLE_UNUSED, 3'h3);
    chk("unallocated", 32'(SRC_NONE), 32'(ref_source_out));
    $display("t_decode done");
  endtask
  task automatic t_gate;
    int p0;
    cfg(MODE_FB_PULSE, ROLE_UNUSED, 3'h7);
    sel(1'b0, 1'b0, 1'b1);
    chk("soft", 32'h1, 32'(soft_start_out));
    sel(1'b0, 1'b0, 1'b0);
    chk("no soft", 32'h0, 32'(soft_start_out));
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("gate status", 32'h610, rd);
    ser_pulse();
    chk("serial blocked", 32'h0, 32'(serial_accept_out));
    p0 = npulse;
    host.pulses(3, 1'b0);
    wt(4);
    chk("dropped", 32'(p0), 32'(npulse));
    @(posedge pclk);
    position_done_in <= 1'b1;
    host.pulses(3, 1'b1);
    wt(4);
    chk("accepted", 32'(p0 + 3), 32'(npulse));
    chk("done out", 32'h1, 32'(position_done_out));
    $display("t_gate done");
  endtask
  task automatic t_idle;
    cfg(MODE_SPD_TRQ, ROLE_UNUSED, 3'h0);
    sel(1'b1, 1'b1, 1'b0);
    chk("fwd limit", 32'h1, 32'(fwd_torque_limit_out));
    chk("rev limit", 32'h0, 32'(rev_torque_limit_out));
    chk("mode switch", 32'h1, 32'(mode_switch_out));
    chk("speed ctrl", 32'h1, 32'(speed_ctrl_out));
    for (int r = 1; r < 3; r++) begin
      cfg(MODE_SPD_TRQ, 2'(r), 3'h0);
      chk("trq role", 32'(r), {30'h0, torque_ffwd_en_out, torque_limit_en_out});
    end
    ser_pulse();
    chk("serial", 32'h1, 32'(serial_accept_out));
    host.set_pins(1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    host.set_pins(1'b1, 1'b0, 1'b0);
    @(negedge pclk);
    chk("glitch", 32'h0, 32'(rev_torque_limit_out));
    wt(ST);
    chk("glitch end", 32'h0, 32'(rev_torque_limit_out));
    cfg(MODE_ZCLAMP, ROLE_UNUSED, 3'h0);
    chk("zero clamp", 32'h1, 32'(zero_clamp_out));
    chk("no speed ctrl", 32'h0, 32'(speed_ctrl_out));
    cfg(MODE_INHIBIT, ROLE_UNUSED, 3'h0);
    chk("inhibit", 32'h1, 32'(inhibit_out));
    cfg(MODE_PI_C, ROLE_UNUSED, 3'h0);
    chk("p control", 32'h1, 32'(p_control_out));
    cfg(MODE_PI_0, ROLE_UNUSED, 3'h0);
    chk("p control 0", 32'h1, 32'(p_control_out));
    chk("no mode switch", 32'h0, 32'(mode_switch_out));
    $display("t_idle done");
  endtask
  initial begin
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_decode();
    t_gate();
    t_idle();
    test_done();
  end
endmodule
